// ==== hdl/lasm_pkg.sv ====
package lasm_pkg;

	// Register geometry
	localparam int unsigned      LASM_DATA_W        = 8;
	localparam int unsigned      LASM_ADDR_W        = 8;
	localparam int unsigned      LASM_SLOT_W        = 3;

	// Register offsets on the internal register port
	localparam logic [7:0]       LASM_OFS_FLAGS     = 8'h01;
	localparam logic [7:0]       LASM_OFS_GATE      = 8'h03;

	// Values after reset
	localparam logic [7:0]       LASM_FLAGS_RST     = 8'h00;
	localparam logic [7:0]       LASM_GATE_RST      = 8'h00;
	localparam logic [7:0]       LASM_RDATA_RST     = 8'h00;
	localparam logic [7:0]       LASM_UNMAPPED_RD   = 8'h00;

	// Implemented status positions per input configuration
	localparam logic [7:0]       LASM_IMPL_SE7_TEMP = 8'hff;
	localparam logic [7:0]       LASM_IMPL_SE8      = 8'hff;
	localparam logic [7:0]       LASM_IMPL_DIFF4    = 8'h8f;
	localparam logic [7:0]       LASM_IMPL_MIXED    = 8'hbf;

	// Position shared by temperature and the eighth input
	localparam int unsigned      LASM_TEMP_BIT      = 7;
	localparam logic [2:0]       LASM_TEMP_SLOT     = 3'h7;

	// Input configuration modes
	typedef enum logic [1:0] {
		LASM_MODE_SE7_TEMP = 2'b00,
		LASM_MODE_SE8      = 2'b01,
		LASM_MODE_DIFF4    = 2'b10,
		LASM_MODE_MIXED    = 2'b11
	} lasm_mode_t;

endpackage : lasm_pkg

// ==== hdl/lasm_bit_map.sv ====
`timescale 1ns/1ps
`default_nettype none

module lasm_bit_map (
	input  wire logic [1:0] mode_sel,
	output logic      [7:0] impl_mask,
	output logic            temp_at_top
);

	// Which status positions exist, and what bit 7 means
	always_comb begin
		case (lasm_pkg::lasm_mode_t'(mode_sel))
			lasm_pkg::LASM_MODE_SE7_TEMP: begin
				impl_mask   = lasm_pkg::LASM_IMPL_SE7_TEMP;
				temp_at_top = 1'b1;
			end
			lasm_pkg::LASM_MODE_SE8: begin
				impl_mask   = lasm_pkg::LASM_IMPL_SE8;
				temp_at_top = 1'b0;
			end
			lasm_pkg::LASM_MODE_DIFF4: begin
				impl_mask   = lasm_pkg::LASM_IMPL_DIFF4;
				temp_at_top = 1'b1;
			end
			lasm_pkg::LASM_MODE_MIXED: begin
				impl_mask   = lasm_pkg::LASM_IMPL_MIXED;
				temp_at_top = 1'b1;
			end
			default: begin
				impl_mask   = lasm_pkg::LASM_IMPL_SE7_TEMP;
				temp_at_top = 1'b1;
			end
		endcase
	end

endmodule : lasm_bit_map

`default_nettype wire

// ==== hdl/lasm_int_pin.sv ====
`timescale 1ns/1ps
`default_nettype none

module lasm_int_pin (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic pending,
	input  wire logic int_enable,
	input  wire logic int_clear,
	output logic      int_out_n,
	output logic      int_oe
);

	logic int_out_n_ff;
	logic nxt_int_out_n;
	logic int_oe_ff;
	logic nxt_int_oe;

	// Pin level and drive; undriven pin relies on the board pull-up
	always_comb begin
		nxt_int_out_n = ~(pending & ~int_clear);
		nxt_int_oe    = int_enable;
	end

	// Registered so the pin never glitches on a mode change
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			int_out_n_ff <= 1'b1;
			int_oe_ff    <= 1'b0;
		end else begin
			int_out_n_ff <= nxt_int_out_n;
			int_oe_ff    <= nxt_int_oe;
		end
	end

	assign int_out_n = int_out_n_ff;
	assign int_oe    = int_oe_ff;

endmodule : lasm_int_pin

`default_nettype wire

// ==== hdl/lasm_alarm_ctrl.sv ====
// Functional notes
// - Status register at 01h, writes ignored
// - Mask register at 03h, read and write
// - Both registers read zero after reset
// - Voltage flag set on high/low excursion
// - Temperature flag only on high excursion
// - Differential mode: four pair flags, temperature
// - Mixed mode: four inputs, two pairs
// - Eight-input mode: bit 7 is input 7
// - Mask bit blocks pin, flag still recorded
// - Differential mode mask gates pairs, temperature
// - Other modes: mask bit gates same position
// - Pin driven only with output enable set
// - Clear deasserts pin, halts loop, keeps flags
// - Disabled channel never raises its flag
`timescale 1ns/1ps
`default_nettype none

module lasm_alarm_ctrl (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Configuration from the control registers
	input  wire logic [1:0] mode_sel,
	input  wire logic       int_enable,
	input  wire logic       int_clear,
	input  wire logic [7:0] chan_disable,
	input  wire logic       chan_disable_wr,
	input  wire logic       init_pulse,
	// Limit comparator results, one per finished conversion
	input  wire logic       conv_done,
	input  wire logic [2:0] conv_slot,
	input  wire logic       above_high,
	input  wire logic       below_low,
	// Internal register port from the serial interface
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	// Interrupt pin and status
	output logic            int_out_n,
	output logic            int_oe,
	output logic            monitor_halt,
	output logic      [7:0] alarm_flags,
	output logic            irq_pending
);

	// Address compare, shared by the write and read decoders
	function automatic logic addr_hit(
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		addr_hit = (addr == ofs);
	endfunction : addr_hit

	logic [7:0] impl_mask;
	logic       temp_at_top;
	logic [7:0] set_vec;
	logic       flags_clr;
	logic       gate_wr;
	logic       pending;

	logic [7:0] flags_ff;
	logic [7:0] nxt_flags;
	logic [7:0] gate_ff;
	logic [7:0] nxt_gate;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic       rvalid_ff;
	logic       nxt_rvalid;

	// Mode decides which positions exist and what bit 7 watches
	lasm_bit_map u_bit_map (
		.mode_sel    (mode_sel),
		.impl_mask   (impl_mask),
		.temp_at_top (temp_at_top)
	);

	// Per-position set terms; the slot number is the status position
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_set
			logic slot_hit;
			logic excursion;
			assign slot_hit = conv_done
				&& (conv_slot == 3'(gi))
				&& impl_mask[gi];
			// Temperature ignores a low excursion
			if (gi == lasm_pkg::LASM_TEMP_BIT) begin : g_top
				assign excursion = above_high
					| (below_low & ~temp_at_top);
			end else begin : g_volt
				assign excursion = above_high | below_low;
			end
			assign set_vec[gi] = slot_hit
				& excursion
				& ~chan_disable[gi];
		end
	endgenerate

	// Status clears on initialisation or a disable reprogram
	assign flags_clr = init_pulse | chan_disable_wr;

	// Status flags: sticky, and a new event beats a clear
	always_comb begin
		nxt_flags = flags_ff;
		if (flags_clr) begin
			nxt_flags = lasm_pkg::LASM_FLAGS_RST;
		end
		// Host writes to the status offset have no path here
		nxt_flags = nxt_flags | set_vec;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flags_ff <= lasm_pkg::LASM_FLAGS_RST;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// Mask register write decode
	assign gate_wr = reg_wr && addr_hit(reg_addr, lasm_pkg::LASM_OFS_GATE);

	// Mask register; a write stores no one in a reserved position, but ones kept from before a mode change stay until init or the next mask write
	always_comb begin
		nxt_gate = gate_ff;
		if (init_pulse) begin
			nxt_gate = lasm_pkg::LASM_GATE_RST;
		end else if (gate_wr) begin
			nxt_gate = reg_wdata & impl_mask;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			gate_ff <= lasm_pkg::LASM_GATE_RST;
		end else begin
			gate_ff <= nxt_gate;
		end
	end

	// Read data mux, one cycle after the read strobe
	always_comb begin
		nxt_rdata  = rdata_ff;
		nxt_rvalid = reg_rd;
		if (reg_rd) begin
			if (addr_hit(reg_addr, lasm_pkg::LASM_OFS_FLAGS)) begin
				nxt_rdata = flags_ff & impl_mask;
			end else if (addr_hit(reg_addr, lasm_pkg::LASM_OFS_GATE)) begin
				nxt_rdata = gate_ff & impl_mask;
			end else begin
				nxt_rdata = lasm_pkg::LASM_UNMAPPED_RD;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata_ff  <= lasm_pkg::LASM_RDATA_RST;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	// Same position in mask gates same position in status
	// Stale bits left by a mode change are hidden, not cleared
	assign pending = |(flags_ff & impl_mask & ~gate_ff);

	// Registered pin driver
	lasm_int_pin u_int_pin (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.pending    (pending),
		.int_enable (int_enable),
		.int_clear  (int_clear),
		.int_out_n  (int_out_n),
		.int_oe     (int_oe)
	);

	// Loop halts for as long as the clear bit stays set
	assign monitor_halt = int_clear;
	assign reg_rdata    = rdata_ff;
	assign reg_rvalid   = rvalid_ff;
	assign alarm_flags  = flags_ff & impl_mask;
	assign irq_pending  = pending;

endmodule : lasm_alarm_ctrl

`default_nettype wire

// ==== verification/lasm_host_pin.sv ====
`timescale 1ns/1ps
`default_nettype none

module lasm_host_pin (
	input  wire logic int_out_n,
	input  wire logic int_oe,
	output logic      pin_level
);
	// Host pull-up holds the line high whenever it is released
	assign pin_level = int_oe ? int_out_n : 1'b1;
endmodule : lasm_host_pin

`default_nettype wire

// ==== verification/lasm_alarm_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

module lasm_alarm_chk (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic [1:0] mode_sel,
	input wire logic       int_enable,
	input wire logic       int_clear,
	input wire logic [7:0] chan_disable,
	input wire logic       conv_done,
	input wire logic [2:0] conv_slot,
	input wire logic       above_high,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic       int_out_n,
	input wire logic       int_oe,
	input wire logic       monitor_halt,
	input wire logic [7:0] alarm_flags,
	input wire logic       irq_pending
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Eight-input mode: every slot exists, bit 7 is a voltage input
	sequence s_hit;
		conv_done && above_high && !chan_disable[conv_slot] && mode_sel == 2'h1;
	endsequence

	// Read answer and its hold
	a_rd_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_rd_quiet: assert property (
		!reg_rd |=> !reg_rvalid && $stable(reg_rdata))
		else $error("read data moved without read");
	// Pin follows its causes one cycle late; halt tracks clear in the same cycle
	a_oe_follow: assert property (
		$past(rst_n) |-> int_oe == $past(int_enable))
		else $error("pin enable wrong");
	a_pin_level: assert property (
		$past(rst_n) |-> int_out_n == !$past(irq_pending && !int_clear))
		else $error("pin level wrong");
	a_clr_halt: assert property (monitor_halt == int_clear)
		else $error("halt not tied to clear");
	// Flag events
	a_flag_set: assert property (
		s_hit |=> alarm_flags[$past(conv_slot)])
		else $error("flag not set");
	a_dis_quiet: assert property (
		conv_done && chan_disable[conv_slot] && !alarm_flags[conv_slot]
		|=> !alarm_flags[$past(conv_slot)])
		else $error("disabled slot flagged");
	a_temp_high: assert property (
		conv_done && mode_sel != 2'h1 && conv_slot == 3'h7 && !above_high
		&& !alarm_flags[7] |=> !alarm_flags[7])
		else $error("temperature flagged on low");
endmodule : lasm_alarm_chk

`default_nettype wire

// ==== verification/lasm_alarm_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module lasm_alarm_ctrl_tb;
	logic sys_clk = 0, rst_n = 0, int_enable = 0, int_clear = 0;
	logic chan_disable_wr = 0, init_pulse = 0, conv_done = 0;
	logic above_high = 0, below_low = 0, reg_wr = 0, reg_rd = 0;
	logic [1:0] mode_sel = 0;
	logic [2:0] conv_slot = 0;
	logic [7:0] chan_disable = 0, reg_addr = 0, reg_wdata = 0;
	logic [7:0] reg_rdata, alarm_flags, st = 0, gm = 0;
	logic reg_rvalid, int_out_n, int_oe, monitor_halt, irq_pending, pin;
	int n_mismatch = 0, num_checks = 0;

	lasm_alarm_ctrl i_dut (.*);
	lasm_host_pin i_host (.int_out_n(int_out_n), .int_oe(int_oe),
		.pin_level(pin));

	// Positions that exist in a mode
	function automatic logic [7:0] imp(input logic [1:0] m);
		return m == 2'h2 ? 8'h8f : m == 2'h3 ? 8'hbf : 8'hff;
	endfunction : imp

	task automatic chk(input string n, input logic [7:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// One strobe cycle; a read is judged when rvalid shows
	task automatic acc(input logic w, input logic [7:0] a, d);
		logic [7:0] e;
		@(negedge sys_clk);
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr = 0;
		reg_rd = 0;
		if (w && a == 8'h03) gm = d & imp(mode_sel);
		e = a == 8'h01 ? st : a == 8'h03 ? gm : 8'h00;
		if (!w) chk("rvalid", 1, reg_rvalid);
		if (!w) chk("rdata", e & imp(mode_sel), reg_rdata);
	endtask : acc

	// Model keeps raw flags; reserved ones are hidden on compare
	task automatic ev(input logic [2:0] s, input logic h, l);
		logic [7:0] m;
		m = imp(mode_sel);
		@(negedge sys_clk);
		conv_done = 1;
		conv_slot = s;
		above_high = h;
		below_low = l;
		if (!chan_disable[s] && m[s] && (h || l && (s != 7 || mode_sel == 1)))
			st[s] = 1;
		@(negedge sys_clk);
		conv_done = 0;
		chk("flags", st & m, alarm_flags);
		chk("pending", |(st & m & ~gm), irq_pending);
	endtask : ev

	// Two cycles let the registered pin settle
	task automatic pc;
		repeat (2) @(negedge sys_clk);
		chk("pin", int_enable ? !(|(st & imp(mode_sel) & ~gm) && !int_clear)
			: 1, pin);
		chk("halt", int_clear, monitor_halt);
		chk("kept", st & imp(mode_sel), alarm_flags);
	endtask : pc

	// Init pulse or disable write, both wipe the flags
	task automatic clr(input logic d, input logic [7:0] dm = 8'hff);
		@(negedge sys_clk);
		init_pulse = !d;
		chan_disable_wr = d;
		if (d) chan_disable = 8'($urandom) & dm;
		@(negedge sys_clk);
		init_pulse = 0;
		chan_disable_wr = 0;
		st = 0;
		if (!d) gm = 0;
		chk("cleared", 0, alarm_flags);
	endtask : clr

	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	// A full run is a few hundred cycles; this only cuts a hang
	initial begin
		#100us;
		n_mismatch++;
		end_sim();
	end

	initial begin
		void'($urandom(32'h68af));
		repeat (3) @(negedge sys_clk);
		rst_n = 1;
		acc(0, 8'h01, 0);
		acc(0, 8'h03, 0);
		for (int m = 0; m < 4; m++) begin
			mode_sel = m[1:0];
			int_enable = m != 0;
			clr(0);
			acc(1, 8'h03, $urandom);
			acc(0, 8'h03, 0);
			// Slot 7 enabled and clean, so a low excursion shows only in eight-input mode
			clr(1, 8'h7f);
			ev(7, 0, 1);
			ev(7, 1, 0);
			clr(1);
			repeat (24) ev($urandom, $urandom, $urandom);
			acc(1, 8'h01, 8'hff);
			acc(0, 8'h01, 0);
			acc(0, 8'h42, 0);
			pc();
			acc(1, 8'h03, 0);
			pc();
			int_clear = 1;
			pc();
			int_clear = 0;
			pc();
			$display("mode %0d done", m);
		end
		// Mid-run reset must wipe a set flag and a set mask
		clr(1, 8'h00);
		ev(0, 1, 0);
		acc(1, 8'h03, 8'hff);
		@(negedge sys_clk);
		rst_n = 0;
		repeat (3) @(negedge sys_clk);
		chk("oe reset", 0, int_oe);
		chk("pin reset", 1, int_out_n);
		rst_n = 1;
		st = 0;
		gm = 0;
		acc(0, 8'h01, 0);
		acc(0, 8'h03, 0);
		$display("reset test done");
		end_sim();
	end
endmodule : lasm_alarm_ctrl_tb

bind lasm_alarm_ctrl lasm_alarm_chk i_chk (.*);

`default_nettype wire
